// ### verilog/sleep_mode_clock_gating.sv
// clock gating control with run, sleep and deep-sleep gating registers
// Behaviour
// RL1 - each implemented bit enables one unit; the code uses implemented bits 9:8 as the adc sample rate select instead
// RL2 - one delivers clock, zero removes it
// RL3 - access to unclocked unit gives bus fault
// RL4 - gating bits reset to zero unless noted; the run and deep registers also reset bit 6 to one
// RL5 - sleep register resets to 0x00000040
// RL6 - separate run, sleep, deep-sleep registers
// RL7 - sleep registers apply only with auto gating
// RL8 - bit 20 pwm, bit 16 adc
// RL9 - reserved bits read zero, ignore writes
// RL10 - unused positions have no gating effect
// RL11 - bits 9:8 select adc sample rate
// RL12 - bit 6 gates hibernation unit
// RL13 - bit 3 gates watchdog, fault if off
// RL14 - run values apply outside auto sleep
`timescale 1ns/10ps
`default_nettype none
module sleep_mode_clock_gating
  import clock_gate_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rdata,
  input wire logic [1:0] power_state,
  input wire logic unit_access,
  input wire logic [1:0] unit_sel,
  output logic unit_fault,
  output logic unit_done,
  output logic pwm_clock_en,
  output logic adc_clock_en,
  output logic hibernation_gate,
  output logic watchdog_gate,
  output logic [1:0] converter_sample_rate_sel
);
  gate_bank_if run_if ();
  gate_bank_if sleep_if ();
  gate_bank_if deep_if ();
  logic [31:0] run_sleep_clock_config_reg;
  logic [31:0] active_gates;
  logic [3:0] enable_next;
  logic [3:0] enable_reg;
  logic [1:0] rate_raw;
  logic [1:0] rate_next;
  logic auto_gating_select;
  power_state_e state;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  assign state = power_state_e'(power_state);
  assign auto_gating_select = run_sleep_clock_config_reg[auto_gate_bit];
  assign run_if.wr = wr_strobe & hit(addr, run_gate_offset); // RL6
  assign sleep_if.wr = wr_strobe & hit(addr, sleep_gate_offset); // RL6
  assign deep_if.wr = wr_strobe & hit(addr, deep_gate_offset); // RL6
  assign run_if.wdata = wdata;
  assign sleep_if.wdata = wdata;
  assign deep_if.wdata = wdata;

  gate_bank #(.reset_value(gate_reset), .writable(gate_writable_mask)) run_bank (
    .clock(clock),
    .rst_n(rst_n),
    .bank(run_if)
  );
  gate_bank #(.reset_value(gate_reset), .writable(gate_writable_mask)) sleep_bank (
    .clock(clock),
    .rst_n(rst_n),
    .bank(sleep_if)
  );
  gate_bank #(.reset_value(gate_reset), .writable(gate_writable_mask)) deep_bank (
    .clock(clock),
    .rst_n(rst_n),
    .bank(deep_if)
  );

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run_sleep_clock_config_reg <= config_reset;
    end else if (wr_strobe && hit(addr, config_offset)) begin
      run_sleep_clock_config_reg <= wdata & config_writable_mask;
    end
  end

  // without auto gating the run register stays in charge in every state
  always_comb begin
    active_gates = run_if.value; // RL14
    if (auto_gating_select) begin // RL7
      unique case (state)
        power_run: active_gates = run_if.value;
        power_sleep: active_gates = sleep_if.value; // RL7
        power_deep: active_gates = deep_if.value;
        default: active_gates = run_if.value;
      endcase
    end
  end

  // only four positions drive a unit; bits 9:8 set the sample rate, others are ignored
  always_comb begin
    enable_next = 4'h0; // RL10
    enable_next[unit_pwm] = active_gates[pwm_bit]; // RL1 RL8
    enable_next[unit_adc] = active_gates[adc_bit]; // RL8
    enable_next[unit_hib] = active_gates[hib_bit]; // RL12
    enable_next[unit_wdt] = active_gates[wdt_bit]; // RL13
    rate_raw = active_gates[rate_lsb+1:rate_lsb];
    // the reserved code 0x3 is capped at the highest supported rate
    rate_next = (rate_raw > rate_500k) ? rate_500k : rate_raw; // RL11
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      // unit order follows the unit codes: wdt, hib, adc, pwm
      enable_reg <= {gate_reset[wdt_bit], gate_reset[hib_bit], gate_reset[adc_bit], gate_reset[pwm_bit]}; // RL4
      converter_sample_rate_sel <= rate_125k;
    end else begin
      enable_reg <= enable_next; // RL2
      converter_sample_rate_sel <= rate_next; // RL11
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pwm_clock_en <= gate_reset[pwm_bit]; // RL4
      adc_clock_en <= gate_reset[adc_bit]; // RL4
      hibernation_gate <= gate_reset[hib_bit]; // RL5
      watchdog_gate <= gate_reset[wdt_bit]; // RL4
    end else begin
      pwm_clock_en <= enable_next[unit_pwm]; // RL2
      adc_clock_en <= enable_next[unit_adc]; // RL2
      hibernation_gate <= enable_next[unit_hib]; // RL12
      watchdog_gate <= enable_next[unit_wdt]; // RL13
    end
  end

  unit_access_check checker_unit (
    .clock(clock),
    .rst_n(rst_n),
    .access(unit_access),
    .unit_sel(unit_sel),
    .enables(enable_reg),
    .fault(unit_fault),
    .done(unit_done)
  );

  // unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (rd_strobe) begin
      unique case (addr)
        run_gate_offset: rdata <= run_if.value;
        sleep_gate_offset: rdata <= sleep_if.value; // RL9
        deep_gate_offset: rdata <= deep_if.value;
        config_offset: rdata <= run_sleep_clock_config_reg;
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule : sleep_mode_clock_gating
`default_nettype wire

// ### pkg/clock_gate_pkg.sv
// constants for the sleep-mode clock gating block
package clock_gate_pkg;
  localparam logic [11:0] run_gate_offset = 12'h100;
  localparam logic [11:0] sleep_gate_offset = 12'h110;
  localparam logic [11:0] deep_gate_offset = 12'h120;
  localparam logic [11:0] config_offset = 12'h060;
  localparam logic [31:0] gate_reset = 32'h00000040;
  localparam logic [31:0] gate_writable_mask = 32'h00110348;
  localparam logic [31:0] config_writable_mask = 32'h08000000;
  localparam logic [31:0] config_reset = 32'h00000000;
  localparam int pwm_bit = 20;
  localparam int adc_bit = 16;
  localparam int rate_lsb = 8;
  localparam int hib_bit = 6;
  localparam int wdt_bit = 3;
  localparam int auto_gate_bit = 27;
  localparam int unit_count = 4;
  localparam logic [1:0] rate_125k = 2'h0;
  localparam logic [1:0] rate_250k = 2'h1;
  localparam logic [1:0] rate_500k = 2'h2;
  localparam logic [1:0] unit_pwm = 2'h0;
  localparam logic [1:0] unit_adc = 2'h1;
  localparam logic [1:0] unit_hib = 2'h2;
  localparam logic [1:0] unit_wdt = 2'h3;
  typedef enum logic [1:0] {
    power_run = 2'b00,
    power_sleep = 2'b01,
    power_deep = 2'b10
  } power_state_e;
endpackage : clock_gate_pkg

// ### pkg/gate_bank_if.sv
// interface carrying one gating register write port and value
`timescale 1ns/10ps
`default_nettype none
interface gate_bank_if;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] value;
  modport owner (input wr, input wdata, output value);
  modport user (output wr, output wdata, input value);
endinterface : gate_bank_if
`default_nettype wire

// ### verilog/gate_bank.sv
// one gating register with masked writable fields
`timescale 1ns/10ps
`default_nettype none
module gate_bank
  import clock_gate_pkg::*;
#(
  parameter logic [31:0] reset_value = gate_reset,
  parameter logic [31:0] writable = gate_writable_mask
) (
  input wire logic clock,
  input wire logic rst_n,
  gate_bank_if.owner bank
);
  logic [31:0] value_reg;
  // reserved bits never store, so they read zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      value_reg <= reset_value; // RL4 RL5
    end else if (bank.wr) begin
      value_reg <= bank.wdata & writable; // RL9
    end
  end
  assign bank.value = value_reg;
endmodule : gate_bank
`default_nettype wire

// ### verilog/unit_access_check.sv
// fault check for bus accesses aimed at a peripheral unit
`timescale 1ns/10ps
`default_nettype none
module unit_access_check
  import clock_gate_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic access,
  input wire logic [1:0] unit_sel,
  input wire logic [3:0] enables,
  output logic fault,
  output logic done
);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fault <= 1'b0;
      done <= 1'b0;
    end else begin
      fault <= access & ~enables[unit_sel]; // RL3 RL13
      done <= access & enables[unit_sel];
    end
  end
endmodule : unit_access_check
`default_nettype wire

// ### testbench/sleep_gating_sva.sv
// port assertions for the sleep gating block
`timescale 1ns/10ps
`default_nettype none
module sleep_gating_sva
  import clock_gate_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rd_strobe,
  input wire logic [31:0] rdata,
  input wire logic unit_access,
  input wire logic [1:0] unit_sel,
  input wire logic unit_fault,
  input wire logic unit_done,
  input wire logic pwm_clock_en,
  input wire logic adc_clock_en,
  input wire logic hibernation_gate,
  input wire logic watchdog_gate,
  input wire logic [1:0] converter_sample_rate_sel
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!rd_strobe |=> rdata == 32'h0) else $error("read data outside read slot");
  resv_zero_a: assert property (rd_strobe |=> (rdata & ~gate_writable_mask & ~config_writable_mask) == 32'h0)
    else $error("reserved bit read as one");
  one_answer_a: assert property (unit_access |=> unit_fault ^ unit_done) else $error("unit access answer wrong");
  no_answer_a: assert property (!unit_access |=> !(unit_fault || unit_done)) else $error("answer without access");
  wdt_fault_a: assert property (unit_access && unit_sel == unit_wdt && !watchdog_gate |=> unit_fault)
    else $error("gated watchdog access not faulted");
  pwm_fault_a: assert property (unit_access && unit_sel == unit_pwm && !pwm_clock_en |=> unit_fault)
    else $error("gated pwm access not faulted");
  hib_done_a: assert property (unit_access && unit_sel == unit_hib && hibernation_gate |=> unit_done)
    else $error("clocked unit access faulted");
  rate_cap_a: assert property (converter_sample_rate_sel != 2'h3) else $error("sample rate above cap");
  reset_gate_a: assert property (!$past(rst_n) |-> hibernation_gate && !watchdog_gate && !pwm_clock_en && !adc_clock_en)
    else $error("gates wrong after reset");
  cover property (unit_access ##1 unit_fault);
  cover property (unit_access ##1 unit_done);
  cover property (rd_strobe ##1 rdata != 32'h0);
endmodule : sleep_gating_sva
`default_nettype wire

// ### testbench/unit_master.sv
// far-side model issuing bus accesses to the peripheral units
`timescale 1ns/10ps
`default_nettype none
module unit_master (
  input wire logic clock,
  input wire logic go,
  input wire logic [1:0] sel,
  output logic unit_access = 1'b0,
  output logic [1:0] unit_sel = 2'h0
);
  // registered so an access always lands one full cycle after the command
  always @(posedge clock) begin
    unit_access <= go;
    unit_sel <= sel;
  end
endmodule : unit_master
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the sleep gating block
`timescale 1ns/10ps
`default_nettype none
module testbench import clock_gate_pkg::*;;
  logic clock = 1'b0, rst_n = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0, go = 1'b0, rd_v = 1'b0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0, v, rdata;
  logic [1:0] power_state = 2'h0, sel = 2'h0, unit_sel, converter_sample_rate_sel;
  logic unit_access, unit_fault, unit_done, pwm_clock_en, adc_clock_en, hibernation_gate, watchdog_gate;
  logic [31:0] rq[$];
  logic [1:0] uq[$];
  int n_errors = 0, n_compared = 0;
  always #2 clock = ~clock;
  sleep_mode_clock_gating dut (.clock, .rst_n, .addr, .wdata, .wr_strobe, .rd_strobe, .rdata, .power_state,
    .unit_access, .unit_sel, .unit_fault, .unit_done, .pwm_clock_en, .adc_clock_en, .hibernation_gate,
    .watchdog_gate, .converter_sample_rate_sel);
  unit_master partner (.clock, .go, .sel, .unit_access, .unit_sel);
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask : check
  task end_sim;
    if (rq.size() + uq.size() != 0) n_errors++;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock);
    rq.push_back(e);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
  endtask : rd
  // r is the gating value in force; indexed by unit number
  task acc(input logic [1:0] s, input logic [31:0] r);
    logic [3:0] b;
    b = {r[wdt_bit], r[hib_bit], r[adc_bit], r[pwm_bit]};
    @(posedge clock);
    uq.push_back(b[s] ? 2'b01 : 2'b10);
    go <= 1'b1;
    sel <= s;
    @(posedge clock);
    go <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : acc
  task en_check(input logic [31:0] r);
    repeat (3) @(posedge clock);
    @(negedge clock);
    check({pwm_clock_en, adc_clock_en, hibernation_gate, watchdog_gate}, {r[20], r[16], r[6], r[3]});
    check(converter_sample_rate_sel, (r[9:8] == 2'h3) ? rate_500k : r[9:8]);
    @(posedge clock);
  endtask : en_check
  always @(posedge clock) rd_v <= rd_strobe;
  always @(negedge clock) begin
    if (rd_v) check(rdata, rq.pop_front());
    if (unit_fault !== 1'b0 || unit_done !== 1'b0) check({unit_fault, unit_done}, uq.pop_front());
  end
  initial begin
    void'($urandom(32'hc6b7));
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(sleep_gate_offset, gate_reset);
    rd(12'h004, 32'h0);
    en_check(gate_reset);
    wr(config_offset, 32'h08000000);
    power_state <= 2'h1;
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'hffffffff : $urandom;
      wr(sleep_gate_offset, v);
      v = v & gate_writable_mask;
      rd(sleep_gate_offset, v);
      en_check(v);
      for (int s = 0; s < 4; s++) acc(s[1:0], v);
    end
    wr(run_gate_offset, 32'h00100008);
    wr(deep_gate_offset, 32'h00010200);
    rd(run_gate_offset, 32'h00100008);
    rd(deep_gate_offset, 32'h00010200);
    rd(config_offset, config_writable_mask);
    power_state <= 2'h2;
    en_check(32'h00010200);
    for (int s = 0; s < 4; s++) acc(s[1:0], 32'h00010200);
    power_state <= 2'h3;
    en_check(32'h00100008);
    power_state <= 2'h0;
    en_check(32'h00100008);
    wr(config_offset, config_reset);
    wr(sleep_gate_offset, 32'h00010340);
    power_state <= 2'h1;
    en_check(32'h00100008);
    // a second reset in mid-run must restore the run, sleep and config registers
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(run_gate_offset, gate_reset);
    rd(sleep_gate_offset, gate_reset);
    rd(config_offset, config_reset);
    en_check(gate_reset);
    for (int s = 0; s < 4; s++) acc(s[1:0], gate_reset);
    end_sim();
  end
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
endmodule : testbench
bind sleep_mode_clock_gating sleep_gating_sva sva (.clock, .rst_n, .rd_strobe, .rdata, .unit_access, .unit_sel,
  .unit_fault, .unit_done, .pwm_clock_en, .adc_clock_en, .hibernation_gate, .watchdog_gate, .converter_sample_rate_sel);
`default_nettype wire
